// *** logic/refr_pkg.sv ***
`default_nettype none
package refr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REFR_OFF_EEPROM_WORD    = 8'h48;
    localparam logic [7:0] REFR_OFF_ROM_POINTER    = 8'h4C;
    localparam logic [7:0] REFR_OFF_ROM_PORT       = 8'h50;
    localparam logic [7:0] REFR_OFF_FIFO_DIAG      = 8'h54;
    localparam logic [7:0] REFR_OFF_PAUSE_RELEASE  = 8'h58;
    localparam logic [7:0] REFR_OFF_PAUSE_ASSERT   = 8'h5C;

    // ------------------------------------------------------------
    // Field widths
    // ------------------------------------------------------------
    localparam int REFR_EE_W  = 16;
    localparam int REFR_PTR_W = 16;
    localparam int REFR_ROM_W = 8;
    localparam int REFR_WM_W  = 11;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] REFR_EE_RST           = 16'h0000;
    localparam logic [15:0] REFR_PTR_RST          = 16'h0000;
    localparam logic [7:0]  REFR_ROM_RST          = 8'h00;
    localparam logic        REFR_DIAG_RST         = 1'b0;
    localparam logic [10:0] REFR_WM_RELEASE_RST   = 11'h000;
    localparam logic [10:0] REFR_WM_ASSERT_RST    = 11'h7FF;

    // ------------------------------------------------------------
    // Diagnostic register bit positions
    // ------------------------------------------------------------
    localparam int REFR_DIAG_TEST_BIT = 0;
    localparam int REFR_DIAG_TX_BIT   = 14;
    localparam int REFR_DIAG_RX_BIT   = 15;

    // ------------------------------------------------------------
    // Pause frame values (quantum of 512 ns)
    // ------------------------------------------------------------
    localparam int          REFR_PAUSE_QUANTUM_NS  = 512;
    localparam logic [15:0] REFR_PAUSE_TIME_RELEASE = 16'h0000;
    localparam logic [15:0] REFR_PAUSE_TIME_ASSERT  = 16'hFFFF;

    typedef enum logic [2:0] {
        REFR_IDLE   = 3'b001,
        REFR_ROM_RD = 3'b010,
        REFR_ROM_WR = 3'b100
    } refr_state_t;

endpackage
`default_nettype wire

// *** logic/refr_cross.sv ***
`timescale 1ns/1ps
`default_nettype none
module refr_cross
    import refr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic cond,
    input  wire logic serve,
    output logic      fire,
    output logic      pending
);

    logic prev_cond;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            prev_cond <= 1'b0;
        end else begin
            prev_cond <= cond;
        end
    end

    // Edge only: a held condition never refires until it drops first
    assign fire = cond & ~prev_cond;

    // New crossing beats a serve in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (fire) begin
            pending <= 1'b1;
        end else if (serve) begin
            pending <= 1'b0;
        end
    end

    chk_single_fire: assert property (@(posedge ref_clk) disable iff (srst)
        fire |=> !fire) else $error("crossing fired twice in a row");
    chk_fire_sets: assert property (@(posedge ref_clk) disable iff (srst)
        fire |=> pending) else $error("crossing not latched");
    chk_rearm_needs_drop: assert property (@(posedge ref_clk) disable iff (srst)
        cond [*2] |-> !fire) else $error("held condition refired");

endmodule
`default_nettype wire

// *** logic/refr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module refr_regs
    import refr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_ack,
    output logic             reg_busy,
    output logic [15:0]      eeprom_word_buffer,
    input  wire logic        ee_load,
    input  wire logic [15:0] ee_load_data,
    output logic [15:0]      rom_byte_pointer,
    output logic             rom_req,
    output logic             rom_we,
    output logic [7:0]       rom_wdata,
    input  wire logic [7:0]  rom_rdata,
    input  wire logic        rom_done,
    input  wire logic        external_data_bus_bit3,
    output logic             buffer_ram_diag_mode,
    input  wire logic        mac_transmitting,
    input  wire logic        rx_receiving,
    input  wire logic [10:0] rx_occupancy,
    output logic             pause_valid,
    output logic [15:0]      pause_time,
    input  wire logic        pause_ack
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] zext16(input logic [15:0] v);
        zext16 = {16'h0000, v};
    endfunction

    function automatic logic [31:0] zext11(input logic [10:0] v);
        zext11 = {21'h000000, v};
    endfunction

    refr_state_t state;
    refr_state_t next_state;

    logic        take;
    logic        acc_rd;
    logic        acc_wr;
    logic        diag_test;
    logic        strap_diag;
    logic [10:0] wm_release;
    logic [10:0] wm_assert;
    logic        above;
    logic        below;
    logic        on_fire;
    logic        off_fire;
    logic        on_pending;
    logic        off_pending;
    logic        serve_on;
    logic        serve_off;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    // Requests while busy are dropped; host must wait for ack
    assign take     = (state == REFR_IDLE);
    assign acc_rd   = take & reg_rd;
    assign acc_wr   = take & reg_wr & ~reg_rd;
    assign reg_busy = ~take;

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            REFR_IDLE: begin
                if (acc_rd && reg_addr == REFR_OFF_ROM_PORT) begin
                    next_state = REFR_ROM_RD;
                end else if (acc_wr && reg_addr == REFR_OFF_ROM_PORT) begin
                    next_state = REFR_ROM_WR;
                end
            end
            REFR_ROM_RD: begin
                if (rom_done) begin
                    next_state = REFR_IDLE;
                end
            end
            REFR_ROM_WR: begin
                if (rom_done) begin
                    next_state = REFR_IDLE;
                end
            end
            default: begin
                next_state = REFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= REFR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ROM is addressed straight from the pointer for the whole access
    assign rom_req = (state == REFR_ROM_RD) | (state == REFR_ROM_WR);
    assign rom_we  = (state == REFR_ROM_WR);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rom_wdata <= REFR_ROM_RST;
        end else if (acc_wr && reg_addr == REFR_OFF_ROM_PORT) begin
            rom_wdata <= reg_wdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // EEPROM word buffer
    // ------------------------------------------------------------
    // Controller load wins so a finished read is never overwritten
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            eeprom_word_buffer <= REFR_EE_RST;
        end else if (ee_load) begin
            eeprom_word_buffer <= ee_load_data;
        end else if (acc_wr && reg_addr == REFR_OFF_EEPROM_WORD) begin
            eeprom_word_buffer <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // ROM byte pointer
    // ------------------------------------------------------------
    // Only a host write moves it, port accesses leave it alone
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rom_byte_pointer <= REFR_PTR_RST;
        end else if (acc_wr && reg_addr == REFR_OFF_ROM_POINTER) begin
            rom_byte_pointer <= reg_wdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // Buffer RAM diagnostics
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            diag_test <= REFR_DIAG_RST;
        end else if (acc_wr && reg_addr == REFR_OFF_FIFO_DIAG) begin
            diag_test <= reg_wdata[REFR_DIAG_TEST_BIT];
        end
    end

    // Strap tracked for the whole reset, last value before release holds
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_diag <= ~external_data_bus_bit3;
        end
    end

    // Software cannot clear a strapped test mode
    assign buffer_ram_diag_mode = diag_test | strap_diag;

    // ------------------------------------------------------------
    // Watermarks
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wm_release <= REFR_WM_RELEASE_RST;
        end else if (acc_wr && reg_addr == REFR_OFF_PAUSE_RELEASE) begin
            wm_release <= reg_wdata[REFR_WM_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wm_assert <= REFR_WM_ASSERT_RST;
        end else if (acc_wr && reg_addr == REFR_OFF_PAUSE_ASSERT) begin
            wm_assert <= reg_wdata[REFR_WM_W-1:0];
        end
    end

    // Occupancy arrives already in 16-byte units
    assign above = rx_occupancy > wm_assert;
    assign below = rx_occupancy < wm_release;

    refr_cross u_cross_assert (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cond    (above),
        .serve   (serve_on),
        .fire    (on_fire),
        .pending (on_pending)
    );

    refr_cross u_cross_release (
        .ref_clk (ref_clk),
        .srst    (srst),
        .cond    (below),
        .serve   (serve_off),
        .fire    (off_fire),
        .pending (off_pending)
    );

    // ------------------------------------------------------------
    // Pause request to the MAC
    // ------------------------------------------------------------
    // Assert is served first: stopping the far end is the urgent case
    assign serve_on  = ~pause_valid & on_pending;
    assign serve_off = ~pause_valid & ~on_pending & off_pending;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pause_valid <= 1'b0;
        end else if (serve_on || serve_off) begin
            pause_valid <= 1'b1;
        end else if (pause_ack) begin
            pause_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pause_time <= REFR_PAUSE_TIME_RELEASE;
        end else if (serve_on) begin
            pause_time <= REFR_PAUSE_TIME_ASSERT;
        end else if (serve_off) begin
            pause_time <= REFR_PAUSE_TIME_RELEASE;
        end
    end

    // ------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (reg_addr)
            REFR_OFF_EEPROM_WORD:   next_rdata = zext16(eeprom_word_buffer);
            REFR_OFF_ROM_POINTER:   next_rdata = zext16(rom_byte_pointer);
            REFR_OFF_FIFO_DIAG: begin
                next_rdata[REFR_DIAG_TEST_BIT] = buffer_ram_diag_mode;
                next_rdata[REFR_DIAG_TX_BIT]   = mac_transmitting;
                next_rdata[REFR_DIAG_RX_BIT]   = rx_receiving;
            end
            REFR_OFF_PAUSE_RELEASE: next_rdata = zext11(wm_release);
            REFR_OFF_PAUSE_ASSERT:  next_rdata = zext11(wm_assert);
            default:                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (state == REFR_ROM_RD && rom_done) begin
            reg_rdata <= {24'h000000, rom_rdata};
        end else if (acc_rd && reg_addr != REFR_OFF_ROM_PORT) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_ack <= 1'b0;
        end else begin
            reg_ack <= (rom_req & rom_done) |
                       ((acc_rd | acc_wr) & (reg_addr != REFR_OFF_ROM_PORT));
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ee_host_write: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_wr && reg_addr == REFR_OFF_EEPROM_WORD && !ee_load) |=>
        eeprom_word_buffer == $past(reg_wdata[15:0])) else $error("word buffer write lost");
    chk_ee_load_wins: assert property (@(posedge ref_clk) disable iff (srst)
        ee_load |=> eeprom_word_buffer == $past(ee_load_data)) else $error("eeprom load lost");
    chk_ptr_write: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_wr && reg_addr == REFR_OFF_ROM_POINTER) |=>
        rom_byte_pointer == $past(reg_wdata[15:0])) else $error("pointer write lost");
    chk_ptr_reserved: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_rd && reg_addr == REFR_OFF_ROM_POINTER) |=>
        reg_ack && reg_rdata[31:16] == 16'h0000) else $error("pointer upper bits nonzero");
    chk_rom_read_data: assert property (@(posedge ref_clk) disable iff (srst)
        (state == REFR_ROM_RD && rom_done) |=>
        reg_ack && reg_rdata == {24'h000000, $past(rom_rdata)}) else $error("rom byte not returned");
    chk_rom_write_data: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_wr && reg_addr == REFR_OFF_ROM_PORT) |=>
        rom_req && rom_we && rom_wdata == $past(reg_wdata[7:0])) else $error("rom write not issued");
    chk_ptr_stable: assert property (@(posedge ref_clk) disable iff (srst)
        rom_req |=> $stable(rom_byte_pointer)) else $error("pointer moved during rom access");
    chk_test_mode: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_wr && reg_addr == REFR_OFF_FIFO_DIAG && reg_wdata[REFR_DIAG_TEST_BIT]) |=>
        buffer_ram_diag_mode) else $error("test mode not entered");
    chk_strap_mode: assert property (@(posedge ref_clk)
        (srst && !external_data_bus_bit3) ##1 !srst |-> buffer_ram_diag_mode)
        else $error("strap test mode missed");
    chk_tx_status: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_rd && reg_addr == REFR_OFF_FIFO_DIAG) |=>
        reg_rdata[REFR_DIAG_TX_BIT] == $past(mac_transmitting)) else $error("tx status wrong");
    chk_rx_status: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_rd && reg_addr == REFR_OFF_FIFO_DIAG) |=>
        reg_rdata[REFR_DIAG_RX_BIT] == $past(rx_receiving)) else $error("rx status wrong");
    chk_wm_width: assert property (@(posedge ref_clk) disable iff (srst)
        (acc_rd && reg_addr == REFR_OFF_PAUSE_ASSERT) |=>
        reg_rdata == zext11($past(wm_assert))) else $error("watermark readback wrong");
    chk_release_time: assert property (@(posedge ref_clk) disable iff (srst)
        ($rose(pause_valid) && !$past(on_pending)) |-> pause_time == REFR_PAUSE_TIME_RELEASE)
        else $error("release pause time wrong");
    chk_assert_time: assert property (@(posedge ref_clk) disable iff (srst)
        ($rose(pause_valid) && $past(on_pending)) |-> pause_time == REFR_PAUSE_TIME_ASSERT)
        else $error("assert pause time wrong");
    chk_one_frame: assert property (@(posedge ref_clk) disable iff (srst)
        (pause_valid && pause_ack && !on_pending && !off_pending) |=> !pause_valid)
        else $error("extra pause frame");
    chk_rearm_cross: assert property (@(posedge ref_clk) disable iff (srst)
        (above && $past(above)) |-> !on_fire) else $error("assert trigger refired");

    cov_rom_read:  cover property (@(posedge ref_clk) disable iff (srst) state == REFR_ROM_RD && rom_done);
    cov_rom_write: cover property (@(posedge ref_clk) disable iff (srst) state == REFR_ROM_WR && rom_done);
    cov_pause_on:  cover property (@(posedge ref_clk) disable iff (srst) serve_on);
    cov_pause_off: cover property (@(posedge ref_clk) disable iff (srst) serve_off);

endmodule
`default_nettype wire

// *** dv/refr_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module refr_regs_tb_top import refr_pkg::*;;

    logic        ref_clk   = 1'b0;
    logic        srst      = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic        reg_rd    = 1'b0;
    logic        reg_wr    = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic        ee_load   = 1'b0;
    logic [15:0] ee_data   = 16'h0000;
    logic [7:0]  rom_rdata = 8'h00;
    logic        rom_done  = 1'b0;
    logic        strap     = 1'b1;
    logic        mac_tx    = 1'b0;
    logic        rx_rcv    = 1'b0;
    logic [10:0] occ       = 11'h000;
    logic        pause_ack = 1'b0;
    logic [31:0] reg_rdata, q;
    logic [15:0] ee_word, rom_ptr, pause_time;
    logic [7:0]  rom_wdata, wr_seen;
    logic [15:0] wr_addr;
    logic        reg_ack, reg_busy, rom_req, rom_we, diag_mode, pause_valid;
    int          fail_count = 0;
    int          checked    = 0;
    int          rom_wait   = 0;

    always #20 ref_clk = ~ref_clk;

    refr_regs DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_busy(reg_busy),
        .eeprom_word_buffer(ee_word), .ee_load(ee_load), .ee_load_data(ee_data), .rom_byte_pointer(rom_ptr),
        .rom_req(rom_req), .rom_we(rom_we), .rom_wdata(rom_wdata), .rom_rdata(rom_rdata), .rom_done(rom_done),
        .external_data_bus_bit3(strap), .buffer_ram_diag_mode(diag_mode), .mac_transmitting(mac_tx),
        .rx_receiving(rx_rcv), .rx_occupancy(occ), .pause_valid(pause_valid), .pause_time(pause_time),
        .pause_ack(pause_ack));

    // ------------------------------------------------------------
    // ROM side: answers after three cycles, byte derived from address
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rom_req === 1'b1 && rom_done !== 1'b1 && rom_wait == 2) begin
            rom_wait <= 0;
            rom_done <= #1 1'b1;
            rom_rdata <= #1 rom_ptr[7:0] ^ 8'h5A;
            if (rom_we === 1'b1) begin
                wr_addr <= rom_ptr;
                wr_seen <= rom_wdata;
            end
        end else begin
            rom_done <= #1 1'b0;
            if (rom_req === 1'b1 && rom_done !== 1'b1) begin
                rom_wait <= rom_wait + 1;
            end
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One access; request held for one cycle, then waits for the answer
    task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        reg_addr = a;
        reg_wr = w;
        reg_rd = !w;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        while (reg_ack !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        q = reg_rdata;
        chk("ack", 32'h0, (n == 50) ? 32'h1 : 32'h0);
    endtask

    task automatic t_reset;
        acc(REFR_OFF_EEPROM_WORD, 1'b0, 32'h0); chk("ee_rst", 32'h0, q);
        acc(REFR_OFF_ROM_POINTER, 1'b0, 32'h0); chk("ptr_rst", 32'h0, q);
        acc(REFR_OFF_FIFO_DIAG, 1'b0, 32'h0); chk("diag_rst", 32'h0, q);
        acc(REFR_OFF_PAUSE_RELEASE, 1'b0, 32'h0); chk("rel_rst", 32'h0, q);
        acc(REFR_OFF_PAUSE_ASSERT, 1'b0, 32'h0); chk("as_rst", 32'h7FF, q);
        acc(8'h60, 1'b0, 32'h0); chk("unmapped", 32'h0, q);
    endtask

    task automatic t_eeprom;
        acc(REFR_OFF_EEPROM_WORD, 1'b1, 32'hFFFF_A5C3);
        acc(REFR_OFF_EEPROM_WORD, 1'b0, 32'h0); chk("ee_rd", 32'h0000_A5C3, q);
        chk("ee_port", 32'hA5C3, {16'h0, ee_word});
        ee_load = 1'b1;
        ee_data = 16'h1234;
        @(posedge ref_clk);
        #1;
        ee_load = 1'b0;
        acc(REFR_OFF_EEPROM_WORD, 1'b0, 32'h0); chk("ee_load", 32'h1234, q);
    endtask

    task automatic t_rom;
        acc(REFR_OFF_ROM_POINTER, 1'b1, 32'hFFFF_0123);
        acc(REFR_OFF_ROM_POINTER, 1'b0, 32'h0); chk("ptr", 32'h0000_0123, q);
        acc(REFR_OFF_ROM_PORT, 1'b0, 32'h0); chk("rom_rd", {24'h0, 8'h23 ^ 8'h5A}, q);
        chk("busy_idle", 32'h0, {30'h0, reg_busy, rom_req});
        acc(REFR_OFF_ROM_PORT, 1'b1, 32'h0000_00C7);
        chk("rom_wr", 32'h0123_00C7, {wr_addr, 8'h00, wr_seen});
        acc(REFR_OFF_ROM_POINTER, 1'b0, 32'h0); chk("ptr_hold", 32'h0000_0123, q);
    endtask

    task automatic t_diag;
        acc(REFR_OFF_FIFO_DIAG, 1'b1, 32'h0000_0001);
        chk("diag_mode", 32'h1, {31'h0, diag_mode});
        mac_tx = 1'b1;
        acc(REFR_OFF_FIFO_DIAG, 1'b0, 32'h0); chk("diag_tx", 32'h4001, q);
        rx_rcv = 1'b1;
        mac_tx = 1'b0;
        acc(REFR_OFF_FIFO_DIAG, 1'b1, 32'h0);
        acc(REFR_OFF_FIFO_DIAG, 1'b0, 32'h0); chk("diag_rx", 32'h8000, q);
        rx_rcv = 1'b0;
    endtask

    // Waits for a frame, checks it, acknowledges it
    task automatic frame(input logic [15:0] t);
        int n;
        n = 0;
        while (pause_valid !== 1'b1 && n < 6) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        chk("pause_valid", 32'h1, {31'h0, pause_valid});
        chk("pause_time", {16'h0, t}, {16'h0, pause_time});
        pause_ack = 1'b1;
        @(posedge ref_clk);
        #1;
        pause_ack = 1'b0;
        chk("pause_drop", 32'h0, {31'h0, pause_valid});
    endtask

    task automatic quiet;
        int n;
        n = 0;
        repeat (8) begin
            @(posedge ref_clk);
            #1;
            if (pause_valid !== 1'b0) n++;
        end
        chk("refire", 32'h0, n);
    endtask

    task automatic t_pause;
        occ = 11'd7;
        acc(REFR_OFF_PAUSE_ASSERT, 1'b1, 32'd10);
        acc(REFR_OFF_PAUSE_RELEASE, 1'b1, 32'd5);
        quiet;
        occ = 11'd10;
        quiet;
        occ = 11'd11;
        frame(REFR_PAUSE_TIME_ASSERT);
        quiet;
        occ = 11'd7;
        quiet;
        occ = 11'd11;
        frame(REFR_PAUSE_TIME_ASSERT);
        occ = 11'd5;
        quiet;
        occ = 11'd4;
        frame(REFR_PAUSE_TIME_RELEASE);
        quiet;
    endtask

    task automatic t_strap;
        srst = 1'b1;
        strap = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        strap = 1'b1;
        chk("strap_mode", 32'h1, {31'h0, diag_mode});
        acc(REFR_OFF_FIFO_DIAG, 1'b1, 32'h0);
        acc(REFR_OFF_FIFO_DIAG, 1'b0, 32'h0); chk("strap_rd", 32'h1, q);
        srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        chk("strap_off", 32'h0, {31'h0, diag_mode});
    endtask

    task automatic test_done;
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        t_reset;
        t_eeprom;
        t_rom;
        t_diag;
        t_pause;
        t_strap;
        test_done;
    end

    // Whole run is about a hundred cycles
    initial begin
        #(40 * 3000);
        fail_count++;
        test_done;
    end

endmodule
`default_nettype wire
